// [core/smc_pkg.sv]
// smc_pkg: constants and carrier types for the sleep mode controller.
// assumes a single 50 MHz clock domain.
package smc_pkg;

    localparam int unsigned CLK_PERIOD_NS     = 20;
    // pulse rejection window and power-down bound, in ns
    localparam int unsigned REJECT_NS         = 100;
    localparam int unsigned PWRDN_MAX_NS      = 400;
    localparam int unsigned REJECT_CYC        = (REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PWRDN_MAX_CYC     = PWRDN_MAX_NS / CLK_PERIOD_NS;
    // wake-up bound, in us (largest part)
    localparam int unsigned PWRUP_MAX_US      = 1000;
    localparam int unsigned PWRUP_MAX_CYC     = PWRUP_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned CNT_W             = 16;
    localparam logic [2:0]  SYNC_RESET        = 3'h7;
    localparam logic [CNT_W-1:0] CNT_RESET    = 16'h0000;

    typedef enum logic [1:0] {
        SMC_NORMAL,
        SMC_SLEEP,
        SMC_WAKE
    } smc_state_t;

    // controls that fan out to the rest of the fabric
    typedef struct packed {
        logic user_run;     // user logic may operate
        logic user_hold;    // user registers held at initial value
        logic io_oe;        // user outputs may drive
        logic tap_en;       // test and programming port enabled
    } smc_ctrl_t;

    localparam smc_ctrl_t CTRL_RESET = '{user_run: 1'b0, user_hold: 1'b1,
                                         io_oe: 1'b0, tap_en: 1'b0};

endpackage : smc_pkg

// [core/smc_sleep_ctrl.sv]
// smc_sleep_ctrl: sleep entry and exit sequencer behind the sleep request pin.
// assumes the pin is asynchronous; the pad pull-up is modelled by an enable input.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - low request pin sleeps; high keeps normal
// - user logic stopped, memory contents lost
// - all user outputs tri-stated while asleep
// - test and programming port disabled asleep
// - request filtered against short glitches
// - sleep entered shortly after valid low
// - weak pull-up holds undriven request inactive
// - wake-up completes after fixed interval
// - power-down within 400 ns of fall
// - power-up 1000 us of wake plus about 10 cycles after rise
module smc_sleep_ctrl #(
    parameter int unsigned WAKE_CYC = smc_pkg::PWRUP_MAX_CYC
) (
    // clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    // request pin, two signals of the pad, and configuration status
    input  wire logic              i_low_power_request_n,
    input  wire logic              i_low_power_request_driven,
    input  wire logic              i_config_busy,
    // fabric controls
    output smc_pkg::smc_ctrl_t     o_ctrl,
    output logic                   o_asleep,
    output logic                   o_mem_clear,
    output logic                   o_req_violation
);

    ////////////////////////////////////////////////////////////////////////////
    // pin conditioning

    logic                          pin_level;
    logic [2:0]                    sync_ff;
    logic                          filt_ff;
    logic [smc_pkg::CNT_W-1:0]     flt_cnt_ff;

    // undriven pin reads high through the pull-up
    assign pin_level = i_low_power_request_driven ? i_low_power_request_n : 1'b1;

    // the first flop may go metastable; only the second and third are compared
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_ff <= smc_pkg::SYNC_RESET;
        end else begin
            sync_ff <= {sync_ff[1:0], pin_level};
        end
    end

    // the filtered level changes only after the new level holds for the
    // rejection window; a shorter pulse restarts the count and is lost
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            filt_ff    <= 1'b1;
            flt_cnt_ff <= smc_pkg::CNT_RESET;
        end else if (sync_ff[1] != sync_ff[2] || sync_ff[2] == filt_ff) begin
            flt_cnt_ff <= smc_pkg::CNT_RESET;
        end else if (flt_cnt_ff == smc_pkg::CNT_W'(smc_pkg::REJECT_CYC - 1)) begin
            filt_ff    <= sync_ff[2];
            flt_cnt_ff <= smc_pkg::CNT_RESET;
        end else begin
            flt_cnt_ff <= flt_cnt_ff + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    smc_pkg::smc_state_t           state_ff;
    logic [smc_pkg::CNT_W-1:0]     wake_cnt_ff;

    // reset lands in wake, so leaving reset costs a full wake-up interval
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff    <= smc_pkg::SMC_WAKE;
            wake_cnt_ff <= smc_pkg::CNT_RESET;
        end else begin
            unique case (state_ff)
                smc_pkg::SMC_NORMAL: begin
                    if (!filt_ff) begin
                        state_ff <= smc_pkg::SMC_SLEEP;
                    end
                end
                smc_pkg::SMC_SLEEP: begin
                    wake_cnt_ff <= smc_pkg::CNT_RESET;
                    if (filt_ff) begin
                        state_ff <= smc_pkg::SMC_WAKE;
                    end
                end
                smc_pkg::SMC_WAKE: begin
                    if (!filt_ff) begin
                        state_ff <= smc_pkg::SMC_SLEEP;
                    end else if (wake_cnt_ff == smc_pkg::CNT_W'(WAKE_CYC - 1)) begin
                        state_ff <= smc_pkg::SMC_NORMAL;
                    end else begin
                        wake_cnt_ff <= wake_cnt_ff + 16'h0001;
                    end
                end
                // the unused code restarts the block as a fresh wake
                default: begin
                    state_ff    <= smc_pkg::SMC_WAKE;
                    wake_cnt_ff <= smc_pkg::CNT_RESET;
                end
            endcase
        end
    end

    // cycles spent in wake, read only by the wake-up bound check
    logic [smc_pkg::CNT_W:0]       wake_age_ff;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wake_age_ff <= {1'b0, smc_pkg::CNT_RESET};
        end else if (state_ff == smc_pkg::SMC_WAKE) begin
            wake_age_ff <= wake_age_ff + 17'h00001;
        end else begin
            wake_age_ff <= {1'b0, smc_pkg::CNT_RESET};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered fabric controls

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ctrl      <= smc_pkg::CTRL_RESET;
            o_asleep    <= 1'b0;
            o_mem_clear <= 1'b0;
        end else begin
            // controls fall straight from the filtered level, on the same edge as the state
            // and a cycle ahead of o_asleep, which keeps power-down well inside its bound
            o_ctrl.user_run  <= (state_ff == smc_pkg::SMC_NORMAL) && filt_ff;
            o_ctrl.user_hold <= (state_ff != smc_pkg::SMC_NORMAL) || !filt_ff;
            o_ctrl.io_oe     <= (state_ff == smc_pkg::SMC_NORMAL) && filt_ff;
            o_ctrl.tap_en    <= (state_ff == smc_pkg::SMC_NORMAL) && filt_ff;
            o_asleep         <= (state_ff == smc_pkg::SMC_SLEEP);
            // contents are dropped on entry rather than kept
            o_mem_clear      <= (state_ff == smc_pkg::SMC_NORMAL) && !filt_ff;
        end
    end

    // flags a request arriving while configuration is loading
    // a flag only: the block cannot refuse the request, it can only report it
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_req_violation <= 1'b0;
        end else begin
            o_req_violation <= i_config_busy && !filt_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // most watch the registered controls, as the fabric sees them; the pin, filter and wake checks watch internal state

    a_down_in_time: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $fell(sync_ff[2]) ##0 (!sync_ff[2])[*5] |-> ##[0:15] !o_ctrl.io_oe)
        else $error("power-down too slow");

    a_glitch_ignored: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (filt_ff && $fell(sync_ff[2])) ##1 !sync_ff[2] ##1 !sync_ff[2] ##1 sync_ff[2]
            |-> (filt_ff)[*4])
        else $error("short low pulse reached the filter");

    a_sleep_tristate: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_asleep |-> !o_ctrl.io_oe && !o_ctrl.tap_en)
        else $error("outputs or test port live in sleep");

    a_hold_no_run: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_ctrl.user_hold |-> !o_ctrl.user_run)
        else $error("user logic runs while held");

    a_low_sleeps: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!filt_ff)[*2] |-> !o_ctrl.user_run)
        else $error("low request did not stop logic");

    a_wake_release: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $rose(o_ctrl.user_run) |-> $past(state_ff) == smc_pkg::SMC_NORMAL && filt_ff)
        else $error("release without finished wake");

    a_clear_on_entry: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (state_ff == smc_pkg::SMC_NORMAL && !filt_ff) |=> o_mem_clear ##1 o_asleep)
        else $error("memory not cleared on entry");

    a_pullup_idle: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!i_low_power_request_driven)[*4] |-> sync_ff[2])
        else $error("undriven pin not read as high");

    a_filter_settled: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $changed(filt_ff) |->
            $past(sync_ff[2], 1) == filt_ff && $past(sync_ff[2], 2) == filt_ff &&
            $past(sync_ff[2], 3) == filt_ff && $past(sync_ff[2], 4) == filt_ff &&
            $past(sync_ff[2], 5) == filt_ff)
        else $error("filtered level moved before the pin settled");

    a_clear_one_pulse: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_mem_clear |=> !o_mem_clear)
        else $error("memory clear longer than one cycle");

    a_flag_config: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_config_busy && !filt_ff) |=> o_req_violation)
        else $error("request during configuration not flagged");

    // the wake counter alone cannot show the bound, so its age is kept apart
    a_wake_bounded: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        state_ff == smc_pkg::SMC_WAKE |-> wake_age_ff < (smc_pkg::CNT_W + 1)'(WAKE_CYC))
        else $error("wake-up took longer than its bound");

    a_release_together: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $fell(o_ctrl.user_hold) |-> o_ctrl.user_run && o_ctrl.io_oe && o_ctrl.tap_en)
        else $error("user controls not released together");

    a_no_run_asleep: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_asleep |-> o_ctrl.user_hold && !o_ctrl.user_run)
        else $error("user logic live in sleep");

endmodule : smc_sleep_ctrl

// [tb/smc_power_mgr.sv]
// smc_power_mgr: behavioural system power manager on the sleep request pin.
// assumes bench commands arrive as levels on the same clock.
`timescale 1ns/100ps
module smc_power_mgr (
    // clock, reset and bench commands
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_want_sleep,
    input  wire logic i_release,
    input  wire logic i_config_busy,
    input  wire logic i_force,
    // pin
    output logic      o_low_power_request_n,
    output logic      o_low_power_request_driven
);
    logic req_n_ff;
    logic drv_ff;
    // never asks for sleep during configuration unless told to misbehave
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_n_ff <= 1'b1;
            drv_ff   <= 1'b1;
        end else begin
            req_n_ff <= !(i_want_sleep && (!i_config_busy || i_force));
            drv_ff   <= !i_release;
        end
    end
    // a released pad shows the level opposite to the pull-up, so the block
    // must rely on its own pull-up and not on a stray level
    assign o_low_power_request_n      = drv_ff ? req_n_ff : 1'b0;
    assign o_low_power_request_driven = drv_ff;
endmodule : smc_power_mgr

// [tb/smc_sleep_ctrl_bench.sv]
// smc_sleep_ctrl_bench: self-checking bench for the sleep sequencer.
// assumes smc_pkg and smc_power_mgr are compiled first.
`timescale 1ns/100ps
module smc_sleep_ctrl_bench;
    localparam int W = 20;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic sleep_cmd = 1'b0;
    logic float_cmd = 1'b0;
    logic bad_cmd = 1'b0;
    logic busy = 1'b0;
    logic req_n, drv, asleep, mclr, viol, seen;
    smc_pkg::smc_ctrl_t ctrl;
    int err_count = 0;
    int check_count = 0;
    int n;
    always #10 i_clock = ~i_clock;
    always @(negedge i_clock) if (mclr === 1'b1) seen = 1'b1;
    smc_power_mgr i_mgr (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_want_sleep(sleep_cmd),
        .i_release(float_cmd), .i_config_busy(busy), .i_force(bad_cmd),
        .o_low_power_request_n(req_n), .o_low_power_request_driven(drv));
    smc_sleep_ctrl #(.WAKE_CYC(W)) i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_low_power_request_n(req_n), .i_low_power_request_driven(drv),
        .i_config_busy(busy), .o_ctrl(ctrl), .o_asleep(asleep), .o_mem_clear(mclr),
        .o_req_violation(viol));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string s, input logic [3:0] e, input logic [3:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic idle(input int c);
        repeat (c) @(negedge i_clock);
    endtask : idle
    // bounded wait; n is the number of cycles taken
    task automatic run_to(input logic r);
        n = 0;
        while ((ctrl.io_oe !== r || ctrl.user_run !== r) && n < 200) begin
            @(negedge i_clock);
            n++;
        end
    endtask : run_to
    task automatic t_boot;
        repeat (2) @(posedge i_clock);
        chk("reset ctrl", 4'h4, ctrl);
        i_rst_n <= 1'b1;
        run_to(1'b1);
        chk("boot time", 4'h1, 4'(n >= W - 1 && n <= W + 12));
        chk("boot ctrl", 4'hb, ctrl);
        $display("boot done");
    endtask : t_boot
    task automatic t_sleep;
        seen = 1'b0;
        @(posedge i_clock) sleep_cmd <= 1'b1;
        run_to(1'b0);
        chk("entry time", 4'h1, 4'(n >= 6 && n <= smc_pkg::PWRDN_MAX_CYC + 1));
        chk("sleep ctrl", 4'h4, ctrl);
        idle(3);
        chk("asleep", 4'h1, 4'(asleep));
        chk("mem clear", 4'h1, 4'(seen));
        @(posedge i_clock) sleep_cmd <= 1'b0;
        run_to(1'b1);
        chk("wake time", 4'h1, 4'(n >= W && n <= W + 14));
        chk("awake", 4'h0, 4'(asleep));
        $display("sleep and wake done");
    endtask : t_sleep
    // a new request during wake goes back to sleep, then wakes in full later
    task automatic t_rewake;
        @(posedge i_clock) sleep_cmd <= 1'b1;
        run_to(1'b0);
        idle(3);
        @(posedge i_clock) sleep_cmd <= 1'b0;
        n = 0;
        while (asleep !== 1'b0 && n < 40) begin
            @(negedge i_clock);
            n++;
        end
        @(posedge i_clock) sleep_cmd <= 1'b1;
        idle(14);
        chk("rewake ctrl", 4'h4, ctrl);
        chk("back asleep", 4'h1, 4'(asleep));
        @(posedge i_clock) sleep_cmd <= 1'b0;
        run_to(1'b1);
        chk("rewake time", 4'h1, 4'(n >= W && n <= W + 14));
        $display("rewake done");
    endtask : t_rewake
    task automatic t_glitch;
        @(posedge i_clock) sleep_cmd <= 1'b1;
        repeat (3) @(posedge i_clock);
        sleep_cmd <= 1'b0;
        idle(20);
        chk("glitch ctrl", 4'hb, ctrl);
        $display("glitch done");
    endtask : t_glitch
    // sleep asked while the pin floats or while configuration loads
    task automatic t_pin(input logic f, input logic b);
        @(posedge i_clock);
        float_cmd <= f;
        busy <= b;
        sleep_cmd <= 1'b1;
        idle(20);
        chk("held ctrl", 4'hb, ctrl);
        chk("no flag", 4'h0, 4'(viol));
        @(posedge i_clock) bad_cmd <= b;
        idle(12);
        chk("flag", 4'(b), 4'(viol));
        @(posedge i_clock) {float_cmd, busy, sleep_cmd, bad_cmd} <= 4'h0;
        run_to(1'b1);
        chk("pin resume", 4'h1, 4'(n < 200));
        $display("pin case done");
    endtask : t_pin
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    initial begin
        idle(3000);
        err_count++;
        stop_test();
    end
    initial begin
        t_boot();
        t_sleep();
        t_rewake();
        t_glitch();
        t_pin(1'b1, 1'b0);
        t_pin(1'b0, 1'b1);
        stop_test();
    end
endmodule : smc_sleep_ctrl_bench
